// ===== core/refresh_cfg.svh
/*
  Constants for the DDR2 refresh and self-refresh device model.
  Assumes inclusion by bare name from core/ files only.
*/
`ifndef REFRESH_CFG_SVH
`define REFRESH_CFG_SVH

`define CLK_PERIOD_PS 25000
// Refresh cycle time, least, in picoseconds.
`define T_RFC_PS 127500
`define RFC_CYCLES ((`T_RFC_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Least clock-enable pulse time in picoseconds.
`define T_CKE_PS 75000
`define CKE_CYCLES ((`T_CKE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Self refresh timer load. The pulse register adds one clock to each run,
// so the first self-timed refresh lands inside the clock-enable pulse time.
`define SELF_TIMER_CYCLES ((`T_CKE_PS / `CLK_PERIOD_PS) - 2)
// Pin levels of a deselect with clock enable high, in synchroniser order:
// cke, cs_n, ras_n, cas_n, we_n, odt.
`define PIN_IDLE 6'h3E
`define BANK_COUNT 8
`define ROW_BITS 14

`endif

// ===== core/refresh_pkg.sv
/*
  Types for the DDR2 refresh device model.
  Assumes refresh_cfg.svh is on the include path.
*/
package refresh_pkg;
  typedef enum logic [2:0] {
    cmd_deselect, cmd_nop, cmd_refresh, cmd_self_entry,
    cmd_precharge, cmd_other
  } command_type;
  typedef enum logic [1:0] {
    st_idle, st_refresh, st_self, st_exit
  } mode_type;
endpackage

// ===== core/refresh_timer.sv
/*
  Down counter that loads on start and pulses done when it runs out.
  Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module refresh_timer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic [WIDTH-1:0] load,
  // Status
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic busy;
    logic done;
  } timer_state_type;
  timer_state_type state;
  timer_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.done = 1'b0;
    if (start) begin
      next_state.count = load;
      next_state.busy = 1'b1;
    end else if (state.busy) begin
      if (state.count <= WIDTH'(1)) begin
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
        next_state.count = '0;
      end else begin
        next_state.count = state.count - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign busy = state.busy;
  assign done = state.done;
endmodule
`default_nettype wire

// ===== core/refresh_device.sv
/*
  DDR2 device-side refresh and self-refresh behaviour: decodes the command
  pins, runs the internal refresh row counter, holds bank idle state, gates
  the internal clock and the DLL in self refresh and self-times refreshes.
  Assumes command pins arrive from the controller asynchronously to clk.
*/
// What this block does
// - Select, row and column strobes low, write high decodes auto refresh.
// - Refresh row comes from the internal counter, not the address pins.
// - Finished refresh leaves every bank precharged and idle.
// - Refresh decode with clock enable low enters self refresh.
// - Clock enable held low keeps self refresh; other inputs ignored.
// - DLL and internal clock are off throughout self refresh.
// - One internal refresh occurs within the clock-enable pulse time.
// - Select low with the three strobes high is a no-op.
`timescale 1ns/1ps
`default_nettype none
`include "refresh_cfg.svh"
module refresh_device #(
  parameter int ROW_BITS = `ROW_BITS,
  parameter int BANKS = `BANK_COUNT,
  parameter int TIMER_BITS = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins from the controller
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic odt,
  input wire logic [BANKS-1:0] precharge_banks,
  input wire logic [BANKS-1:0] activate_banks,
  // Device state
  output logic [BANKS-1:0] bank_idle,
  output logic [ROW_BITS-1:0] refresh_row,
  output logic refresh_pulse,
  output logic refresh_busy,
  output logic self_refresh,
  output logic dll_enable,
  output logic internal_clock_enable,
  output logic termination_on,
  output refresh_pkg::mode_type mode
);
  import refresh_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pins pass a two-stage synchroniser before any decode reads them.
  // The bank masks ride the same stages, so they stay aligned with it.
  localparam int PIN_BITS = 6 + 2 * BANKS;
  logic [PIN_BITS-1:0] pin_meta;
  logic [PIN_BITS-1:0] pin_sync;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Reset to an idle bus, so the first decode never sees a stray command.
      pin_meta <= {`PIN_IDLE, {(2 * BANKS){1'b0}}};
      pin_sync <= {`PIN_IDLE, {(2 * BANKS){1'b0}}};
    end else begin
      pin_meta <= {cke, cs_n, ras_n, cas_n, we_n, odt,
                   precharge_banks, activate_banks};
      pin_sync <= pin_meta;
    end
  end

  logic s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_odt;
  logic [BANKS-1:0] s_pre, s_act;
  assign {s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_odt, s_pre, s_act} =
    pin_sync;

  ////////////////////////////////////////////////////////////////////////
  // Deselect and no-op leave all state but the sampled odt alone; neither ends a refresh.
  command_type command;

  always_comb begin
    command = cmd_other;
    if (s_cs_n) begin
      command = cmd_deselect;
    end else if (s_ras_n && s_cas_n && s_we_n) begin
      command = cmd_nop;
    end else if (!s_ras_n && !s_cas_n && s_we_n) begin
      command = s_cke ? cmd_refresh : cmd_self_entry;
    end else if (!s_ras_n && s_cas_n && !s_we_n) begin
      command = cmd_precharge;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // The shared timer serves both the refresh cycle and the self-refresh
  // interval; they never overlap, which saves a second counter.
  logic timer_start;
  logic [TIMER_BITS-1:0] timer_load;
  logic timer_busy;
  logic timer_done;

  refresh_timer #(
    .WIDTH(TIMER_BITS)
  ) timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(timer_start),
    .load(timer_load),
    .busy(timer_busy),
    .done(timer_done)
  );

  // Mode, row counter and bank idle bits share one register, so a refresh,
  // its row step and its pulse always land on the same edge.
  typedef struct packed {
    mode_type mode;
    logic [ROW_BITS-1:0] row;
    logic [BANKS-1:0] idle;
    logic pulse;
    logic odt_seen;
  } device_state_type;
  device_state_type state;
  device_state_type next_state;

  always_comb begin
    next_state = state;
    next_state.pulse = 1'b0;
    timer_start = 1'b0;
    timer_load = TIMER_BITS'(`RFC_CYCLES);
    next_state.odt_seen = s_odt;
    case (state.mode)
      st_idle: begin
        if (command == cmd_precharge) begin
          next_state.idle = state.idle | s_pre;
        end else if (command == cmd_other) begin
          // Any other selected command opens the banks on activate_banks;
          // the bank comes from that port, not from an address decode.
          next_state.idle = state.idle & ~s_act;
        end else if (command == cmd_refresh) begin
          next_state.mode = st_refresh;
          next_state.pulse = 1'b1;
          next_state.row = state.row + ROW_BITS'(1);
          timer_start = 1'b1;
        end else if (command == cmd_self_entry) begin
          // The first self-timed refresh follows within the clock-enable
          // pulse time, so no row is starved across the entry.
          next_state.mode = st_self;
          timer_start = 1'b1;
          timer_load = TIMER_BITS'(`SELF_TIMER_CYCLES);
        end
      end
      st_refresh: begin
        // Commands are dropped until the refresh cycle time has run out.
        if (timer_done) begin
          next_state.mode = st_idle;
          next_state.idle = '1;
        end
      end
      st_self: begin
        // Only clock enable is looked at here.
        if (timer_done) begin
          next_state.pulse = 1'b1;
          next_state.row = state.row + ROW_BITS'(1);
          timer_start = 1'b1;
          timer_load = TIMER_BITS'(`SELF_TIMER_CYCLES);
        end
        // Raising clock enable cuts a self-timed run short; the exit timer
        // then covers a full refresh cycle, so no row is left half done.
        if (s_cke) begin
          next_state.mode = st_exit;
          timer_start = 1'b1;
          timer_load = TIMER_BITS'(`RFC_CYCLES);
        end
      end
      st_exit: begin
        // A refresh running at exit finishes before commands are decoded.
        if (timer_done) begin
          next_state.mode = st_idle;
          next_state.idle = '1;
        end
      end
      default: begin
        // All four encodings are used; a mode with unknown bits falls back to idle rather than locking up.
        next_state.mode = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{mode: st_idle, row: '0, idle: '1, pulse: 1'b0,
                 odt_seen: 1'b0};
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign bank_idle = state.idle;
  assign refresh_row = state.row;
  assign refresh_pulse = state.pulse;
  assign refresh_busy = timer_busy;
  assign mode = state.mode;
  assign self_refresh = (state.mode == st_self);
  // The DLL and internal clock return as soon as exit is seen, while
  // commands stay ignored until the exit timer has run out.
  assign dll_enable = (state.mode != st_self);
  assign internal_clock_enable = (state.mode != st_self);
  assign termination_on = state.odt_seen && (state.mode != st_self);
endmodule
`default_nettype wire

// ===== sim/refresh_device_props.sv
/*
  Port checker for refresh_device.
  Assumes the bind below and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module refresh_device_props
  import refresh_pkg::*;
#(parameter int ROW_BITS = 14, parameter int BANKS = 8) (
  // Clock, reset and pins
  input wire logic clk, rst_n, cke, cs_n, ras_n, cas_n, we_n,
  // Device state
  input wire logic [BANKS-1:0] bank_idle,
  input wire logic [ROW_BITS-1:0] refresh_row,
  input wire logic refresh_pulse, self_refresh, dll_enable,
  input wire logic internal_clock_enable,
  input wire mode_type mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ref_pins = !cs_n && !ras_n && !cas_n && we_n;
  wire nop_pins = cke && !cs_n && ras_n && cas_n && we_n;
  ////////////////////////////////////////////////////////////////////////////
  a_refresh_decode: assert property (
    mode == st_idle && $past(cke && ref_pins, 2)
    |=> refresh_pulse && mode == st_refresh) else $error("no refresh");
  a_self_entry: assert property (
    mode == st_idle && $past(!cke && ref_pins, 2)
    |=> mode == st_self && !dll_enable) else $error("no self entry");
  a_nop_ignored: assert property (
    mode == st_idle && $past(nop_pins, 2)
    |=> mode == st_idle && !refresh_pulse) else $error("nop acted");
  a_row_advance: assert property (
    refresh_pulse |-> refresh_row == $past(refresh_row) + 1'b1)
    else $error("row not advanced");
  a_refresh_idle: assert property (
    $rose(mode == st_refresh) |-> ##[6:8] (mode == st_idle && &bank_idle))
    else $error("banks not idle");
  a_self_hold: assert property (
    mode == st_self && !$past(cke, 2) |=> mode == st_self)
    else $error("self refresh left");
  a_clock_gated: assert property (
    mode == st_self |-> self_refresh && !dll_enable && !internal_clock_enable)
    else $error("clock not gated");
  a_self_timer: assert property (
    $rose(mode == st_self) |-> ##[0:2] refresh_pulse)
    else $error("no self refresh pulse");
  c_refresh: cover property (refresh_pulse && mode == st_refresh);
  c_self: cover property (mode == st_self && refresh_pulse);
  c_exit: cover property (mode == st_exit);
endmodule
bind refresh_device refresh_device_props #(.ROW_BITS(ROW_BITS),
  .BANKS(BANKS)) chk_u (.*);
`default_nettype wire

// ===== sim/ddr2_cmd_driver.sv
/*
  Controller model driving the command pins one command at a time.
  Assumes the bench calls send() from a single process.
*/
`timescale 1ns/1ps
`default_nettype none
module ddr2_cmd_driver
  import refresh_pkg::*;
(
  // Clock
  input wire logic clk,
  // Command pins
  output logic cke, cs_n, ras_n, cas_n, we_n, odt
);
  initial {cke, cs_n, ras_n, cas_n, we_n, odt} = 6'h3E;
  // Gap cycles deselect with toggling strobes so stale levels never match.
  task automatic send(input command_type c, input int gap);
    @(posedge clk);
    cke <= c != cmd_self_entry;
    odt <= 1'b0;
    cs_n <= 1'b0;
    ras_n <= c == cmd_nop;
    cas_n <= !(c inside {cmd_refresh, cmd_self_entry});
    we_n <= c != cmd_precharge;
    repeat (gap) begin
      @(posedge clk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= ~{ras_n, cas_n, we_n};
      odt <= !cke && !odt;
    end
  endtask
endmodule
`default_nettype wire

// ===== sim/test_ddr2_refresh_precharge_timing.sv
/*
  Bench for refresh_device with a controller model on the pins.
  Assumes the design files and refresh_device_props are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_ddr2_refresh_precharge_timing;
  import refresh_pkg::*;
  logic clk = 0, rst_n = 0, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic refresh_pulse, refresh_busy, self_refresh, dll_enable;
  logic internal_clock_enable, termination_on;
  logic [7:0] precharge_banks = 8'h00, activate_banks = 8'h00, bank_idle;
  logic [13:0] refresh_row, row_exp = 14'h0000;
  logic [31:0] seed = 32'hEA46;
  mode_type mode;
  int mismatches = 0, n_checks = 0, cycles = 0;
  // Controller-side spacings; the write terms are plain defaults.
  localparam int WL = 2, BL = 4, WR = 3, RP_CYCLES = 3;
  localparam int T_RFC_PS = 127500, CLK_PS = 25000, REF_POSTED = 3;
  // Pins reach the mode register three edges after they are driven, and a
  // refresh ends one edge after its timer runs out.
  localparam int PIPE_EDGES = 4;
  int rfc_gap;
  ddr2_cmd_driver drv_u (.*);
  refresh_device dut_u (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int round_up_cycles(input int t_ps, input int p_ps);
    return (t_ps + p_ps - 1) / p_ps;
  endfunction
  task automatic chk(input logic [15:0] got, exp);
    #1;
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cycles == 2000) begin
    mismatches++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk(bank_idle, 8'hFF);
    chk(mode, st_idle);
    chk(dll_enable, 1'b1);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      activate_banks <= seed[7:0];
      drv_u.send(cmd_other, WL + BL / 2 + WR);
      precharge_banks <= seed[15:8];
      drv_u.send(cmd_precharge, 4);
      chk(bank_idle, 8'(~seed[7:0] | seed[15:8]));
      precharge_banks <= 8'hFF;
      drv_u.send(cmd_precharge, RP_CYCLES + 1);
      chk(bank_idle, 8'hFF);
      drv_u.send(cmd_nop, 4);
      chk(mode, st_idle);
      chk(refresh_row, row_exp);
    end
    $display("bank open and close done");
    rfc_gap = round_up_cycles(T_RFC_PS, CLK_PS) + PIPE_EDGES;
    for (int i = 0; i < REF_POSTED; i++) begin
      seed = lfsr(seed);
      drv_u.send(cmd_refresh, rfc_gap + seed[1:0]);
      row_exp++;
      chk(refresh_row, row_exp);
      chk(mode, st_idle);
      chk(refresh_busy, 1'b0);
    end
    $display("auto refresh done");
    for (int i = 0; i < 2; i++) begin
      drv_u.send(cmd_self_entry, 10);
      chk(mode, st_self);
      chk(self_refresh, 1'b1);
      chk(termination_on, 1'b0);
      chk(refresh_row > row_exp, 1'b1);
      drv_u.send(cmd_nop, 12);
      chk(mode, st_idle);
      chk(self_refresh, 1'b0);
      chk(dll_enable & internal_clock_enable, 1'b1);
      row_exp = refresh_row;
      drv_u.send(cmd_refresh, 10);
      chk(refresh_row, 14'(row_exp + 1'b1));
    end
    $display("self refresh done");
    report_and_stop();
  end
endmodule
`default_nettype wire
